//--- hw/dacc_consts.svh
// Offsets, field positions, reset values and codes of the shared converter control block.
// Assumes inclusion by bare name from the design file.
`ifndef DACC_CONSTS_SVH
`define DACC_CONSTS_SVH
`define DACC_OFF_COMMON 8'h00
`define DACC_OFF_TRIG 8'h04
`define DACC_OFF_ENABLE 8'h08
`define DACC_OFF_GO 8'h0C
`define DACC_OFF_IRQ_STAT 8'h10
`define DACC_OFF_IRQ_EN 8'h14
`define DACC_OFF_IRQ_CLR 8'h18
`define DACC_OFF_RESULT 8'h1C
`define DACC_BIT_JUSTIFY 7
`define DACC_BIT_GO_ALL 2
`define DACC_COMMON_WMASK 8'hF3
`define DACC_COMMON_RESET 8'h00
`define DACC_TRIG_RESET 3'h0
`define DACC_CLK_RC 3'h7
`define DACC_REF_VDD 2'h0
`define DACC_REF_RSVD 2'h1
`define DACC_REF_EXT 2'h2
`define DACC_CONV_CYCLES 4'hB
`endif

//--- hw/dacc_pkg.sv
// Types shared by the shared converter control block.
// Assumes the constants header is on the include path.
package dacc_pkg;
  typedef enum logic [1:0] {DACC_IDLE, DACC_RUN} dacc_conv_e;
  typedef logic [7:0] dacc_byte_t;
endpackage

//--- hw/dacc_common_ctrl.sv
// Shared control of two converters: common control byte, auto trigger, per-converter go flags, AXI4-Lite slave.
// Assumes synchronous inputs on aclk and a single AXI4-Lite master with one write and one read at a time.
`timescale 1ns/1ps
`include "dacc_consts.svh"

// Contract
// - Justify bit selects right or left results.
// - Sync go starts only enabled converters.
// - Sync go reads one while converting.
// - Auto trigger sets both go flags.
// - Sync go reads OR of go flags.
// - Channel switches active only when enabled.
module dacc_common_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] trig_sources,
  input wire logic [1:0] conv_done,
  input wire logic [9:0] raw_result0,
  input wire logic [9:0] raw_result1,
  input wire logic [13:0] chan_sel0,
  input wire logic [13:0] chan_sel1,
  output logic [1:0] per_converter_go,
  output logic [1:0] converter_on,
  output logic [13:0] chan_switch0,
  output logic [13:0] chan_switch1,
  output logic [2:0] conv_clock_select,
  output logic rc_conv_clock,
  output logic [1:0] pos_ref_select,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  dacc_pkg::dacc_byte_t common_r;
  logic [2:0] auto_trigger_select_r;
  logic [7:0] trig_prev_r;
  logic [1:0] go_r;
  logic [1:0] on_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  logic [15:0] result_r;
  logic [1:0] go_fall;
  logic [1:0] go_prev_r;
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic sync_go_wr;
  logic trig_fire;
  logic [31:0] rd_nxt;
  logic rd_ok;
  logic wr_ok;

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign sync_go_wr = wr_fire && aw_addr_r == `DACC_OFF_COMMON && w_strb_r[0] && w_data_r[`DACC_BIT_GO_ALL];

  // ---------------------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    case (aw_addr_r)
      `DACC_OFF_COMMON, `DACC_OFF_TRIG, `DACC_OFF_ENABLE, `DACC_OFF_IRQ_EN, `DACC_OFF_IRQ_CLR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      common_r <= `DACC_COMMON_RESET;
      auto_trigger_select_r <= `DACC_TRIG_RESET;
      on_r <= 2'h0;
      irq_en_r <= 2'h0;
    end
    else if (wr_fire && w_strb_r[0])
    begin
      if (aw_addr_r == `DACC_OFF_COMMON)
      begin
        // The reserved reference code is not stored; the field keeps its value.
        if (w_data_r[1:0] == `DACC_REF_RSVD)
          common_r <= (w_data_r[7:0] & `DACC_COMMON_WMASK & 8'hFC) | {6'h00, common_r[1:0]};
        else
          common_r <= w_data_r[7:0] & `DACC_COMMON_WMASK;
      end
      if (aw_addr_r == `DACC_OFF_TRIG)
        auto_trigger_select_r <= w_data_r[6:4];
      if (aw_addr_r == `DACC_OFF_ENABLE)
        on_r <= w_data_r[1:0];
      if (aw_addr_r == `DACC_OFF_IRQ_EN)
        irq_en_r <= w_data_r[1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Auto trigger: codes 0 to 2 select nothing, others pick a source edge
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      trig_prev_r <= 8'h00;
    else
      trig_prev_r <= trig_sources;
  end

  always_comb
  begin
    case (auto_trigger_select_r)
      3'h0, 3'h1, 3'h2: trig_fire = 1'b0;
      3'h7: trig_fire = trig_prev_r[7] && !trig_sources[7];
      default: trig_fire = trig_sources[auto_trigger_select_r] && !trig_prev_r[auto_trigger_select_r];
    endcase
  end

  // ---------------------------------------------------------------------------
  // Per-converter go flags
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_conv
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          go_r[gi] <= 1'b0;
        else if (sync_go_wr && on_r[gi])
          go_r[gi] <= 1'b1;
        else if (trig_fire)
          go_r[gi] <= 1'b1;
        else if (conv_done[gi] || !on_r[gi])
          go_r[gi] <= 1'b0;
      end
      assign go_fall[gi] = go_prev_r[gi] && !go_r[gi];
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      go_prev_r <= 2'h0;
    else
      go_prev_r <= go_r;
  end

  // ---------------------------------------------------------------------------
  // Device outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      per_converter_go <= 2'h0;
      converter_on <= 2'h0;
      chan_switch0 <= 14'h0000;
      chan_switch1 <= 14'h0000;
      conv_clock_select <= 3'h0;
      rc_conv_clock <= 1'b0;
      pos_ref_select <= `DACC_REF_VDD;
      irq <= 1'b0;
    end
    else
    begin
      per_converter_go <= go_r;
      converter_on <= on_r;
      chan_switch0 <= on_r[0] ? chan_sel0 : 14'h0000;
      chan_switch1 <= on_r[1] ? chan_sel1 : 14'h0000;
      conv_clock_select <= common_r[6:4];
      rc_conv_clock <= common_r[6:4] == `DACC_CLK_RC;
      pos_ref_select <= common_r[1:0];
      irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // ---------------------------------------------------------------------------
  // Completion status: set wins over clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_r <= 2'h0;
    else if (wr_fire && w_strb_r[0] && aw_addr_r == `DACC_OFF_IRQ_CLR)
      irq_stat_r <= (irq_stat_r & ~w_data_r[1:0]) | go_fall;
    else
      irq_stat_r <= irq_stat_r | go_fall;
  end

  // ---------------------------------------------------------------------------
  // Justified result of converter 0
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_r <= 16'h0000;
    else if (go_fall[0])
    begin
      if (common_r[`DACC_BIT_JUSTIFY])
        result_r <= {6'h00, raw_result0};
      else
        result_r <= {raw_result0, 6'h00};
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `DACC_OFF_COMMON: rd_nxt = {24'h000000, common_r[7:3], |go_r, common_r[1:0]};
      `DACC_OFF_TRIG: rd_nxt = {25'h0000000, auto_trigger_select_r, 4'h0};
      `DACC_OFF_ENABLE: rd_nxt = {30'h00000000, on_r};
      `DACC_OFF_GO: rd_nxt = {30'h00000000, go_r};
      `DACC_OFF_IRQ_STAT: rd_nxt = {30'h00000000, irq_stat_r};
      `DACC_OFF_IRQ_EN: rd_nxt = {30'h00000000, irq_en_r};
      `DACC_OFF_IRQ_CLR: rd_nxt = 32'h00000000;
      `DACC_OFF_RESULT: rd_nxt = {16'h0000, result_r};
      default:
      begin
        rd_nxt = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- verif/dacc_ctrl_monitor.sv
// Concurrent checks on the ports of the shared converter control block.
// Assumes it is bound into the top module, whose port names it reuses.
`timescale 1ns/1ps
module dacc_ctrl_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [1:0] per_converter_go,
  input wire logic [1:0] converter_on,
  input wire logic [13:0] chan_switch0,
  input wire logic [2:0] conv_clock_select,
  input wire logic rc_conv_clock,
  input wire logic [1:0] pos_ref_select,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------
  // Assertions.
  // ----------
  chk_rc_clock_code: assert property (rc_conv_clock == (conv_clock_select == 3'h7))
    else $error("rc clock flag disagrees with clock code");
  chk_switch_gated_off: assert property (!converter_on[0] |-> chan_switch0 == 14'h0)
    else $error("switch closed on a disabled converter");
  chk_ref_not_reserved: assert property (pos_ref_select != 2'h1)
    else $error("reserved reference code driven");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  cover property (per_converter_go == 2'h3);
  cover property ($rose(irq));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind dacc_common_ctrl dacc_ctrl_monitor u_mon (.*);

//--- verif/dacc_tb.sv
// Self-checking bench for the shared converter control block over AXI4-Lite.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
module tb;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, trig_sources = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rc_conv_clock, irq, aw, w;
  logic [1:0] s_axi_bresp, s_axi_rresp, per_converter_go, converter_on, pos_ref_select, rsp, conv_done = 2'h0;
  logic [9:0] raw_result0 = 10'h2C5, raw_result1 = 10'h000;
  logic [13:0] chan_sel0 = 14'h1555, chan_sel1 = 14'h2AAA, chan_switch0, chan_switch1;
  logic [2:0] conv_clock_select;
  int failures = 0, comparisons = 0, cycles = 0;
  dacc_common_ctrl u_dut (.*);
  always #25 aclk = ~aclk;
  // ----------
  // Bus and check tasks.
  // ----------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    aw = 1'h0;
    w = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw = aw | (s_axi_awready === 1'h1);
      w = w | (s_axi_wready === 1'h1);
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(name, d, exp);
  endtask
  task automatic conv_end(input logic [1:0] m);
    conv_done <= m;
    @(posedge aclk);
    conv_done <= 2'h0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic end_sim;
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      end_sim;
    end
  end
  // ----------
  // Test sequence.
  // ----------
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    chk("outputs", {irq, per_converter_go, converter_on, pos_ref_select, rc_conv_clock, conv_clock_select}, 32'h0);
    rchk("common", 8'h00, 32'h0);
    wr(8'h00, 32'hF2);
    rchk("common", 8'h00, 32'hF2);
    chk("rc_clock", rc_conv_clock, 32'h1);
    chk("clock_sel", conv_clock_select, 32'h7);
    chk("ref", pos_ref_select, 32'h2);
    wr(8'h00, 32'h71);
    rchk("ref_rsvd", 8'h00, 32'h72);
    chk("switch_off", chan_switch0, 32'h0);
    wr(8'h08, 32'h1);
    @(negedge aclk);
    chk("switch0", chan_switch0, 32'h1555);
    chk("switch1", chan_switch1, 32'h0);
    wr(8'h00, 32'h76);
    rchk("busy", 8'h00, 32'h76);
    chk("go", per_converter_go, 32'h1);
    conv_end(2'h1);
    rchk("idle", 8'h00, 32'h72);
    rchk("left", 8'h1C, 32'hB140);
    rchk("status", 8'h10, 32'h1);
    wr(8'h14, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq_on", irq, 32'h1);
    wr(8'h14, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_masked", irq, 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq_clear", irq, 32'h0);
    rchk("status_clr", 8'h10, 32'h0);
    wr(8'h08, 32'h3);
    @(negedge aclk);
    chk("switch1_on", chan_switch1, 32'h2AAA);
    wr(8'h00, 32'hF2);
    wr(8'h04, 32'h30);
    trig_sources <= 8'h08;
    repeat (3) @(posedge aclk);
    chk("auto_go", per_converter_go, 32'h3);
    rchk("auto_busy", 8'h00, 32'hF6);
    raw_result0 <= 10'h13A;
    conv_end(2'h3);
    rchk("right", 8'h1C, 32'h13A);
    wr(8'h20, 32'h1);
    chk("bad_wr", rsp, 32'h2);
    wr(8'h10, 32'h1);
    chk("ro_wr", rsp, 32'h2);
    rd(8'h24);
    chk("bad_rd", rsp, 32'h2);
    end_sim;
  end
endmodule
